// ==== core/ecc_config.sv ====
// Contract
// [R1] Half-duty select set: both sources high half of each period, high time ignored.
// [R2] Otherwise high time equals the 11-bit field times the step; field resets zero.
// [R3] Step follows master-frequency select; code 00 gives 30.52 us; the step counts 1220 core cycles, 30.50 us.
// [R4] Bit 23 inverts the channel input when set; resets clear.
// [R5] Bit 21 set isolates the positive electrode input; resets set.
// [R6] Bit 20 set isolates the negative electrode input; resets set.
// [R7] Positive route 19:18: none, mid-supply, positive source, negative source.
// [R8] Negative route 17:16 decodes the same way; resets to 00.
// [R9] Routing to a calibration source acts only while source enable is set.
// [R10] Channel config writes may disturb samples; software may resynchronise afterwards.
// [R11] Rate field 23:22 resets to 10, decoded against master-frequency select.
// [R12] Master code 00: rates 512, 256, 128 sps; code 11 reserved.
// [R13] Master code 01: rates 500, 250, 125 sps; code 11 reserved.
// [R14] Master code 10: only rate 10 valid, giving 200 sps.
// [R15] Master code 11: only rate 10 valid, giving 199.8 sps.
// [R16] Gain 17:16 selects 20, 40, 80, 160 V/V; resets 00.
// [R17] Bit 14 clear bypasses high-pass, set gives 0.5 Hz; resets set.
// [R18] Unsupported low-pass setting runs as 01, stored as written, read back effective.
// [R19] Step is 31.25 us for master codes 01 and 10, 31.28 us for 11.
// [R20] Source enable clear disables all calibration sources and modes; resets clear.
// [R21] High-time counts whole steps from each period start, sources high until reached.
`timescale 1ns/1ps
`default_nettype none
module ecc_config (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [23:0] reg_rdata,
  input wire logic [1:0] master_freq_sel,
  input wire logic cal_freq_level,
  input wire logic resync_cmd,
  output logic cal_source_pos,
  output logic cal_source_neg,
  output logic channel_invert,
  output logic pos_input_isolate,
  output logic neg_input_isolate,
  output logic pos_to_midsupply_ref,
  output logic pos_to_cal_source_pos,
  output logic pos_to_cal_source_neg,
  output logic neg_to_midsupply_ref,
  output logic neg_to_cal_source_pos,
  output logic neg_to_cal_source_neg,
  output logic [15:0] sample_rate_dsps,
  output logic sample_rate_valid,
  output logic [7:0] gain_sel_vv,
  output logic highpass_sel,
  output logic [1:0] lowpass_eff,
  output logic cfg_changed,
  output logic resync_pending
);
  typedef struct packed {
    logic cal_sources_enable;
    logic vmode;
    logic vmag;
    logic [2:0] fcal;
    logic cal_half_duty_sel;
    logic [10:0] cal_high_time;
    logic channel_invert;
    logic pos_input_isolate;
    logic neg_input_isolate;
    logic [1:0] pos_cal_route;
    logic [1:0] neg_cal_route;
    logic [1:0] sample_rate_sel;
    logic [1:0] gain_sel;
    logic highpass_sel;
    logic [1:0] lowpass_sel;
    logic [23:0] rdata;
    logic [2:0] pos_sw;
    logic [2:0] neg_sw;
    logic [15:0] rate_dsps;
    logic rate_ok;
    logic [7:0] gain_vv;
    logic [1:0] lpf_eff;
    logic changed;
    logic pending;
  } ecc_main_state_t;

  ecc_main_state_t st;
  ecc_main_state_t next_st;
  ecc_cal_if cal ();

  // Switch set {to negative source, to positive source, to mid-supply}
  function automatic logic [2:0] route_sw(input logic [1:0] code, input logic en);
    unique case (ecc_pkg::ecc_route_t'(code))
      ecc_pkg::ROUTE_NONE: route_sw = 3'h0;
      ecc_pkg::ROUTE_MID: route_sw = 3'h1;
      ecc_pkg::ROUTE_CALP: route_sw = en ? 3'h2 : 3'h0; // [R9]
      ecc_pkg::ROUTE_CALN: route_sw = en ? 3'h4 : 3'h0; // [R9]
    endcase
  endfunction

  // Sample rate in tenths of samples per second; zero for reserved codes
  function automatic logic [15:0] rate_of(input logic [1:0] fsel, input logic [1:0] rate);
    rate_of = 16'h0000;
    unique case (fsel)
      2'h0: begin // [R12]
        unique case (rate)
          2'h0: rate_of = 16'h1400;
          2'h1: rate_of = 16'h0A00;
          2'h2: rate_of = 16'h0500;
          2'h3: rate_of = 16'h0000;
        endcase
      end
      2'h1: begin // [R13]
        unique case (rate)
          2'h0: rate_of = 16'h1388;
          2'h1: rate_of = 16'h09C4;
          2'h2: rate_of = 16'h04E2;
          2'h3: rate_of = 16'h0000;
        endcase
      end
      2'h2: rate_of = (rate == 2'h2) ? 16'h07D0 : 16'h0000; // [R14]
      2'h3: rate_of = (rate == 2'h2) ? 16'h07CE : 16'h0000; // [R15]
    endcase
  endfunction

  // Effective low-pass code for the current rate
  function automatic logic [1:0] lpf_of(input logic [1:0] fsel, input logic [1:0] rate,
                                        input logic [1:0] lpf);
    logic fast;
    logic mid;
    fast = !fsel[1] && (rate == 2'h0);
    mid = !fsel[1] && (rate == 2'h1);
    if (lpf == 2'h0 || lpf == 2'h1) begin
      lpf_of = lpf;
    end else if (fast || (mid && lpf == 2'h2)) begin
      lpf_of = lpf;
    end else begin
      lpf_of = ecc_pkg::LPF_FALLBACK; // [R18]
    end
  endfunction

  function automatic logic [7:0] gain_of(input logic [1:0] g);
    unique case (g)
      2'h0: gain_of = 8'h14;
      2'h1: gain_of = 8'h28;
      2'h2: gain_of = 8'h50;
      2'h3: gain_of = 8'hA0;
    endcase
  endfunction

  assign cal.freq_sel = master_freq_sel;
  assign cal.cal_on = st.cal_sources_enable; // [R20]
  assign cal.half_duty = st.cal_half_duty_sel;
  assign cal.high_steps = st.cal_high_time;
  assign cal.freq_level = cal_freq_level;

  ecc_step_gen u_step (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .cal(cal.step)
  );

  ecc_wave_gen u_wave (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .cal(cal.wave_gen)
  );

  always_comb begin
    next_st = st;
    next_st.rdata = 24'h000000;
    next_st.changed = 1'b0;
    if (reg_rd) begin
      unique case (reg_addr)
        ecc_pkg::ADDR_CAL: begin
          next_st.rdata[ecc_pkg::CAL_EN_BIT] = st.cal_sources_enable;
          next_st.rdata[ecc_pkg::CAL_VMODE_BIT] = st.vmode;
          next_st.rdata[ecc_pkg::CAL_VMAG_BIT] = st.vmag;
          next_st.rdata[ecc_pkg::CAL_FCAL_LSB +: 3] = st.fcal;
          next_st.rdata[ecc_pkg::CAL_HALF_BIT] = st.cal_half_duty_sel;
          next_st.rdata[ecc_pkg::CAL_CAL_HIGH_TIME_LSB +: 11] = st.cal_high_time;
        end
        ecc_pkg::ADDR_EMUX: begin
          next_st.rdata[ecc_pkg::EMUX_INV_BIT] = st.channel_invert;
          next_st.rdata[ecc_pkg::EMUX_POS_ISO_BIT] = st.pos_input_isolate;
          next_st.rdata[ecc_pkg::EMUX_NEG_ISO_BIT] = st.neg_input_isolate;
          next_st.rdata[ecc_pkg::EMUX_POS_ROUTE_LSB +: 2] = st.pos_cal_route;
          next_st.rdata[ecc_pkg::EMUX_NEG_ROUTE_LSB +: 2] = st.neg_cal_route;
        end
        ecc_pkg::ADDR_ECG: begin
          next_st.rdata[ecc_pkg::SAMPLE_RATE_SEL_LSB +: 2] = st.sample_rate_sel;
          next_st.rdata[ecc_pkg::GAIN_SEL_LSB +: 2] = st.gain_sel;
          next_st.rdata[ecc_pkg::ECG_HPF_BIT] = st.highpass_sel;
          next_st.rdata[ecc_pkg::ECG_LPF_LSB +: 2] = // [R18]
            lpf_of(master_freq_sel, st.sample_rate_sel, st.lowpass_sel);
        end
        default: begin
          next_st.rdata = 24'h000000;
        end
      endcase
    end
    if (reg_wr) begin
      unique case (reg_addr)
        ecc_pkg::ADDR_CAL: begin
          next_st.cal_sources_enable = reg_wdata[ecc_pkg::CAL_EN_BIT];
          next_st.vmode = reg_wdata[ecc_pkg::CAL_VMODE_BIT];
          next_st.vmag = reg_wdata[ecc_pkg::CAL_VMAG_BIT];
          next_st.fcal = reg_wdata[ecc_pkg::CAL_FCAL_LSB +: 3];
          next_st.cal_half_duty_sel = reg_wdata[ecc_pkg::CAL_HALF_BIT];
          next_st.cal_high_time = reg_wdata[ecc_pkg::CAL_CAL_HIGH_TIME_LSB +: 11];
        end
        ecc_pkg::ADDR_EMUX: begin
          next_st.channel_invert = reg_wdata[ecc_pkg::EMUX_INV_BIT];
          next_st.pos_input_isolate = reg_wdata[ecc_pkg::EMUX_POS_ISO_BIT];
          next_st.neg_input_isolate = reg_wdata[ecc_pkg::EMUX_NEG_ISO_BIT];
          next_st.pos_cal_route = reg_wdata[ecc_pkg::EMUX_POS_ROUTE_LSB +: 2];
          next_st.neg_cal_route = reg_wdata[ecc_pkg::EMUX_NEG_ROUTE_LSB +: 2];
        end
        ecc_pkg::ADDR_ECG: begin
          next_st.sample_rate_sel = reg_wdata[ecc_pkg::SAMPLE_RATE_SEL_LSB +: 2];
          next_st.gain_sel = reg_wdata[ecc_pkg::GAIN_SEL_LSB +: 2];
          next_st.highpass_sel = reg_wdata[ecc_pkg::ECG_HPF_BIT];
          // Stored as written; only the effective copy is narrowed
          next_st.lowpass_sel = reg_wdata[ecc_pkg::ECG_LPF_LSB +: 2];
          next_st.changed = 1'b1; // [R10]
        end
        default: begin
          next_st.changed = 1'b0;
        end
      endcase
    end
    // A channel config write in the same cycle as the command keeps the flag set
    if (next_st.changed) begin
      next_st.pending = 1'b1; // [R10]
    end else if (resync_cmd) begin
      next_st.pending = 1'b0;
    end
    // Derived controls settle one cycle after the register they follow
    next_st.pos_sw = route_sw(st.pos_cal_route, st.cal_sources_enable); // [R7]
    next_st.neg_sw = route_sw(st.neg_cal_route, st.cal_sources_enable); // [R8]
    next_st.rate_dsps = rate_of(master_freq_sel, st.sample_rate_sel); // [R11]
    next_st.rate_ok = rate_of(master_freq_sel, st.sample_rate_sel) != 16'h0000;
    next_st.gain_vv = gain_of(st.gain_sel); // [R16]
    next_st.lpf_eff = lpf_of(master_freq_sel, st.sample_rate_sel, st.lowpass_sel); // [R18]
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
      st.cal_sources_enable <= ecc_pkg::RST_CAL_EN; // [R20]
      st.vmode <= ecc_pkg::RST_VMODE;
      st.vmag <= ecc_pkg::RST_VMAG;
      st.fcal <= ecc_pkg::RST_FCAL;
      st.cal_half_duty_sel <= ecc_pkg::RST_HALF;
      st.cal_high_time <= ecc_pkg::RST_CAL_HIGH_TIME; // [R2]
      st.channel_invert <= ecc_pkg::RST_INV; // [R4]
      st.pos_input_isolate <= ecc_pkg::RST_ISO; // [R5]
      st.neg_input_isolate <= ecc_pkg::RST_ISO; // [R6]
      st.pos_cal_route <= ecc_pkg::RST_ROUTE;
      st.neg_cal_route <= ecc_pkg::RST_ROUTE; // [R8]
      st.sample_rate_sel <= ecc_pkg::RST_RATE; // [R11]
      st.gain_sel <= ecc_pkg::RST_GAIN; // [R16]
      st.highpass_sel <= ecc_pkg::RST_HPF; // [R17]
      st.lowpass_sel <= ecc_pkg::RST_LPF;
      st.gain_vv <= gain_of(ecc_pkg::RST_GAIN); // [R16]
      st.lpf_eff <= ecc_pkg::RST_LPF;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign cal_source_pos = cal.wave; // [R1]
  assign cal_source_neg = cal.wave; // [R1]
  assign channel_invert = st.channel_invert; // [R4]
  assign pos_input_isolate = st.pos_input_isolate; // [R5]
  assign neg_input_isolate = st.neg_input_isolate; // [R6]
  assign pos_to_midsupply_ref = st.pos_sw[0];
  assign pos_to_cal_source_pos = st.pos_sw[1];
  assign pos_to_cal_source_neg = st.pos_sw[2];
  assign neg_to_midsupply_ref = st.neg_sw[0];
  assign neg_to_cal_source_pos = st.neg_sw[1];
  assign neg_to_cal_source_neg = st.neg_sw[2];
  assign sample_rate_dsps = st.rate_dsps;
  assign sample_rate_valid = st.rate_ok;
  assign gain_sel_vv = st.gain_vv;
  assign highpass_sel = st.highpass_sel; // [R17]
  assign lowpass_eff = st.lpf_eff;
  assign cfg_changed = st.changed;
  assign resync_pending = st.pending;
endmodule
`default_nettype wire

// ==== core/ecc_step_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecc_step_gen (
  input wire logic core_clk,
  input wire logic sys_rst,
  ecc_cal_if.step cal
);
  typedef struct packed {
    logic [10:0] count;
    logic tick;
  } ecc_step_state_t;

  ecc_step_state_t st;
  ecc_step_state_t next_st;

  function automatic logic [10:0] step_len(input logic [1:0] fsel);
    unique case (fsel)
      2'h0: step_len = ecc_pkg::STEP_FM00_CYC;
      2'h1: step_len = ecc_pkg::STEP_FM01_CYC;
      2'h2: step_len = ecc_pkg::STEP_FM10_CYC;
      2'h3: step_len = ecc_pkg::STEP_FM11_CYC;
    endcase
  endfunction

  assign cal.step_tick = st.tick;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!cal.cal_on || cal.step_sync) begin
      next_st.count = 11'h000;
    end else if (st.count >= step_len(cal.freq_sel) - 11'h001) begin // [R3] [R19]
      next_st.count = 11'h000;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + 11'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ==== core/ecc_wave_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecc_wave_gen (
  input wire logic core_clk,
  input wire logic sys_rst,
  ecc_cal_if.wave_gen cal
);
  typedef struct packed {
    ecc_pkg::ecc_wave_t phase;
    logic [10:0] count;
    logic freq_prev;
    logic wave;
  } ecc_wave_state_t;

  ecc_wave_state_t st;
  ecc_wave_state_t next_st;
  logic rise;

  // Step timer restarts with each period so steps line up with its start
  assign rise = cal.freq_level && !st.freq_prev;
  assign cal.step_sync = rise;
  assign cal.wave = st.wave;

  always_comb begin
    next_st = st;
    next_st.freq_prev = cal.freq_level;
    if (!cal.cal_on) begin // [R20]
      next_st.phase = ecc_pkg::WAVE_IDLE;
      next_st.count = 11'h000;
      next_st.wave = 1'b0;
    end else if (cal.half_duty) begin
      next_st.phase = ecc_pkg::WAVE_IDLE;
      next_st.count = 11'h000;
      next_st.wave = cal.freq_level; // [R1]
    end else if (rise) begin
      next_st.count = 11'h000;
      if (cal.high_steps == 11'h000) begin // [R2]
        next_st.phase = ecc_pkg::WAVE_LOW;
        next_st.wave = 1'b0;
      end else begin
        next_st.phase = ecc_pkg::WAVE_HIGH;
        next_st.wave = 1'b1;
      end
    end else begin
      unique case (st.phase)
        ecc_pkg::WAVE_IDLE: begin
          next_st.wave = 1'b0;
        end
        ecc_pkg::WAVE_HIGH: begin
          if (cal.step_tick) begin
            if (st.count + 11'h001 >= cal.high_steps) begin // [R21] [R2]
              next_st.phase = ecc_pkg::WAVE_LOW;
              next_st.wave = 1'b0;
            end else begin
              next_st.count = st.count + 11'h001;
            end
          end
        end
        ecc_pkg::WAVE_LOW: begin
          next_st.wave = 1'b0;
        end
        default: begin
          next_st.phase = ecc_pkg::WAVE_IDLE;
          next_st.wave = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ==== include/ecc_cal_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ecc_cal_if;
  logic [1:0] freq_sel;
  logic cal_on;
  logic half_duty;
  logic [10:0] high_steps;
  logic freq_level;
  logic step_sync;
  logic step_tick;
  logic wave;
  modport ctl (output freq_sel, cal_on, half_duty, high_steps, freq_level, input wave);
  modport step (input freq_sel, cal_on, step_sync, output step_tick);
  modport wave_gen (input cal_on, half_duty, high_steps, freq_level, step_tick,
                    output step_sync, wave);
endinterface
`default_nettype wire

// ==== include/ecc_pkg.sv ====
package ecc_pkg;
  // Core clock
  localparam int CLK_PERIOD_NS = 25;
  // Calibration time step per master-frequency code
  localparam int STEP_FM00_NS = 30520;
  localparam int STEP_FM01_NS = 31250;
  localparam int STEP_FM10_NS = 31250;
  localparam int STEP_FM11_NS = 31280;
  localparam logic [10:0] STEP_FM00_CYC = 11'(STEP_FM00_NS / CLK_PERIOD_NS);
  localparam logic [10:0] STEP_FM01_CYC = 11'(STEP_FM01_NS / CLK_PERIOD_NS);
  localparam logic [10:0] STEP_FM10_CYC = 11'(STEP_FM10_NS / CLK_PERIOD_NS);
  localparam logic [10:0] STEP_FM11_CYC = 11'(STEP_FM11_NS / CLK_PERIOD_NS);

  // Register offsets
  localparam logic [7:0] ADDR_CAL = 8'h12;
  localparam logic [7:0] ADDR_EMUX = 8'h14;
  localparam logic [7:0] ADDR_ECG = 8'h15;

  // calibration_source_config fields
  localparam int CAL_EN_BIT = 22;
  localparam int CAL_VMODE_BIT = 21;
  localparam int CAL_VMAG_BIT = 20;
  localparam int CAL_FCAL_LSB = 12;
  localparam int CAL_HALF_BIT = 11;
  localparam int CAL_CAL_HIGH_TIME_LSB = 0;
  // channel_input_mux_config fields
  localparam int EMUX_INV_BIT = 23;
  localparam int EMUX_POS_ISO_BIT = 21;
  localparam int EMUX_NEG_ISO_BIT = 20;
  localparam int EMUX_POS_ROUTE_LSB = 18;
  localparam int EMUX_NEG_ROUTE_LSB = 16;
  // channel_config fields
  localparam int SAMPLE_RATE_SEL_LSB = 22;
  localparam int GAIN_SEL_LSB = 16;
  localparam int ECG_HPF_BIT = 14;
  localparam int ECG_LPF_LSB = 12;

  // Reset values and the low-pass fallback code
  localparam logic RST_CAL_EN = 1'h0;
  localparam logic RST_VMODE = 1'h0;
  localparam logic RST_VMAG = 1'h0;
  localparam logic [2:0] RST_FCAL = 3'h4;
  localparam logic RST_HALF = 1'h1;
  localparam logic [10:0] RST_CAL_HIGH_TIME = 11'h000;
  localparam logic RST_INV = 1'h0;
  localparam logic RST_ISO = 1'h1;
  localparam logic [1:0] RST_ROUTE = 2'h0;
  localparam logic [1:0] RST_RATE = 2'h2;
  localparam logic [1:0] RST_GAIN = 2'h0;
  localparam logic RST_HPF = 1'h1;
  localparam logic [1:0] RST_LPF = 2'h1;
  localparam logic [1:0] LPF_FALLBACK = 2'h1;

  typedef enum logic [1:0] {
    ROUTE_NONE = 2'b00,
    ROUTE_MID = 2'b01,
    ROUTE_CALP = 2'b10,
    ROUTE_CALN = 2'b11
  } ecc_route_t;

  typedef enum logic [1:0] {
    WAVE_IDLE = 2'b00,
    WAVE_HIGH = 2'b01,
    WAVE_LOW = 2'b10
  } ecc_wave_t;
endpackage

// ==== testbench/ecc_config_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecc_config_properties (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [23:0] reg_rdata,
  input wire logic resync_cmd,
  input wire logic cal_source_pos,
  input wire logic cal_source_neg,
  input wire logic channel_invert,
  input wire logic pos_input_isolate,
  input wire logic neg_input_isolate,
  input wire logic pos_to_midsupply_ref,
  input wire logic pos_to_cal_source_pos,
  input wire logic pos_to_cal_source_neg,
  input wire logic [15:0] sample_rate_dsps,
  input wire logic sample_rate_valid,
  input wire logic [7:0] gain_sel_vv,
  input wire logic cfg_changed,
  input wire logic resync_pending
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 24'h000000)
    else $error("read data not zero outside read answer");
  a_unmapped_read: assert property ($past(reg_rd && reg_addr != ecc_pkg::ADDR_CAL
    && reg_addr != ecc_pkg::ADDR_EMUX && reg_addr != ecc_pkg::ADDR_ECG) |-> reg_rdata == 24'h0)
    else $error("unmapped read not zero");
  a_ecg_reserved: assert property ($past(reg_rd && reg_addr == ecc_pkg::ADDR_ECG)
    |-> (reg_rdata & 24'h3C8FFF) == 24'h0)
    else $error("reserved channel config bits not zero");
  a_cfg_pulse: assert property (reg_wr && reg_addr == ecc_pkg::ADDR_ECG
    |=> cfg_changed && resync_pending) else $error("config write not flagged");
  a_cfg_cause: assert property (cfg_changed
    |-> $past(reg_wr && reg_addr == ecc_pkg::ADDR_ECG))
    else $error("config change flag without write");
  a_resync_clear: assert property (resync_cmd && !(reg_wr && reg_addr == ecc_pkg::ADDR_ECG)
    |=> !resync_pending) else $error("resync did not clear pending");
  a_mux_bits: assert property (
    $past(reg_wr && reg_addr == ecc_pkg::ADDR_EMUX, 2)
    |-> channel_invert == $past(reg_wdata[23], 2) && pos_input_isolate == $past(reg_wdata[21], 2)
    && neg_input_isolate == $past(reg_wdata[20], 2)
    && pos_to_midsupply_ref == ($past(reg_wdata[19:18], 2) == 2'h1))
    else $error("mux outputs do not follow written bits");
  a_route_onehot: assert property ($onehot0({pos_to_midsupply_ref, pos_to_cal_source_pos,
    pos_to_cal_source_neg})) else $error("positive route switches not one-hot");
  a_src_equal: assert property (cal_source_pos == cal_source_neg)
    else $error("calibration sources differ");
  a_rate_valid: assert property (sample_rate_valid == (sample_rate_dsps != 16'h0000))
    else $error("rate valid disagrees with rate value");
  a_gain_legal: assert property (gain_sel_vv inside {8'h14, 8'h28, 8'h50, 8'hA0})
    else $error("gain value outside the four settings");
endmodule
`default_nettype wire

// ==== testbench/ecc_config_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecc_config_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] master_freq_sel = 2'h0;
  logic cal_freq_level = 1'b0;
  logic resync_cmd = 1'b0;
  logic [23:0] reg_rdata;
  logic cal_source_pos, cal_source_neg, channel_invert, pos_input_isolate, neg_input_isolate;
  logic pos_to_midsupply_ref, pos_to_cal_source_pos, pos_to_cal_source_neg;
  logic neg_to_midsupply_ref, neg_to_cal_source_pos, neg_to_cal_source_neg;
  logic [15:0] sample_rate_dsps;
  logic sample_rate_valid, highpass_sel, cfg_changed, resync_pending;
  logic [7:0] gain_sel_vv;
  logic [1:0] lowpass_eff;
  int err_count = 0;
  int n_checks = 0;
  logic [31:0] rnd_state = 32'h8ABB64BC;

  ecc_config uut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .master_freq_sel, .cal_freq_level, .resync_cmd, .cal_source_pos, .cal_source_neg,
    .channel_invert, .pos_input_isolate, .neg_input_isolate, .pos_to_midsupply_ref,
    .pos_to_cal_source_pos, .pos_to_cal_source_neg, .neg_to_midsupply_ref,
    .neg_to_cal_source_pos, .neg_to_cal_source_neg, .sample_rate_dsps, .sample_rate_valid,
    .gain_sel_vv, .highpass_sel, .lowpass_eff, .cfg_changed, .resync_pending);

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    rnd_state = rnd_state ^ (rnd_state << 13);
    rnd_state = rnd_state ^ (rnd_state >> 17);
    rnd_state = rnd_state ^ (rnd_state << 5);
    return rnd_state;
  endfunction

  // Rate in tenths of sps, 0 where the code is reserved
  function automatic int exp_dsps(input int fm, input int r);
    if (fm < 2) return (r == 3) ? 0 : ((fm == 0) ? 5120 : 5000) >> r;
    return (r != 2) ? 0 : ((fm == 2) ? 2000 : 1998);
  endfunction

  function automatic int exp_lpf(input int fm, input int r, input int l);
    int top;
    // Reserved rates keep bypass and 01, anything higher falls back
    top = (fm < 2 && r == 0) ? 3 : (fm < 2 && r == 1) ? 2 : 1;
    return (l > top) ? 1 : l;
  endfunction

  // Step rounds down to whole core cycles
  function automatic int step_cyc(input int fm);
    return ((fm == 0) ? 30520 : (fm == 3) ? 31280 : 31250) / 25;
  endfunction

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Ends 1 ns after the taking edge, so write effects are visible
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [23:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // Counts high cycles after one rise of the calibration frequency
  task automatic cal_run(input int fm, input int en, input int ht);
    int cnt;
    int ex;
    cnt = 0;
    ex = (en == 1) ? ht * step_cyc(fm) : 0;
    master_freq_sel <= 2'(fm);
    wr(ecc_pkg::ADDR_CAL, 24'((en << 22) | ht));
    cal_freq_level <= 1'b1;
    repeat (ex + 40) begin
      @(posedge core_clk);
      #1;
      if (cal_source_pos === 1'b1) cnt++;
    end
    cal_freq_level <= 1'b0;
    n_checks++;
    if (cnt < ex || cnt > ex + 2) begin
      err_count++;
      $display("wrong value cal high cycles expected %0d seen %0d", ex, cnt);
    end
  endtask

  initial begin
    int p, n, en, fm, r, l;
    logic lv;
    logic [23:0] d, v;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(ecc_pkg::ADDR_CAL, v);
    // Source frequency field 100 at 14:12 plus half-duty bit 11
    chk("cal reset", 24'h004800, v);
    rd(ecc_pkg::ADDR_EMUX, v);
    chk("mux reset", 24'h300000, v);
    rd(ecc_pkg::ADDR_ECG, v);
    chk("config reset", 24'h805000, v);
    rd(8'h13, v);
    chk("unmapped read", 24'h000000, v);
    chk("reset outputs", 24'h000003, 24'({pos_input_isolate, neg_input_isolate}));
    chk("reset gain", 24'h000014, 24'(gain_sel_vv));
    for (en = 0; en < 2; en++) begin
      wr(ecc_pkg::ADDR_CAL, 24'(en << 22));
      for (p = 0; p < 4; p++) begin
        for (n = 0; n < 4; n++) begin
          d = 24'(rnd() & 32'h00B00000) | 24'(p << 18) | 24'(n << 16);
          wr(ecc_pkg::ADDR_EMUX, d);
          settle();
          chk("mux bits", d & 24'hB00000, 24'({channel_invert, 1'b0, pos_input_isolate,
            neg_input_isolate, 20'h0}));
          chk("pos switches", 24'({p == 3 && en == 1, p == 2 && en == 1, p == 1}),
            24'({pos_to_cal_source_neg, pos_to_cal_source_pos,
            pos_to_midsupply_ref}));
          chk("neg switches", 24'({n == 3 && en == 1, n == 2 && en == 1, n == 1}),
            24'({neg_to_cal_source_neg, neg_to_cal_source_pos,
            neg_to_midsupply_ref}));
          rd(ecc_pkg::ADDR_EMUX, v);
          chk("mux readback", d, v);
        end
      end
    end
    for (fm = 0; fm < 4; fm++) begin
      master_freq_sel <= 2'(fm);
      for (r = 0; r < 4; r++) begin
        for (l = 0; l < 4; l++) begin
          d = 24'(rnd() & 32'h00034000) | 24'(r << 22) | 24'(l << 12);
          wr(ecc_pkg::ADDR_ECG, d);
          chk("config flags", 24'h000003, 24'({cfg_changed, resync_pending}));
          settle();
          chk("rate", 24'(exp_dsps(fm, r)),
            24'(sample_rate_dsps));
          chk("rate valid", 24'(exp_dsps(fm, r) != 0), 24'(sample_rate_valid));
          chk("gain", 24'(20 << d[17:16]), 24'(gain_sel_vv));
          chk("highpass", 24'(d[14]), 24'(highpass_sel));
          chk("lowpass", 24'(exp_lpf(fm, r, l)), 24'(lowpass_eff));
          rd(ecc_pkg::ADDR_ECG, v);
          chk("config readback", (d & 24'hFFCFFF) | 24'(exp_lpf(fm, r, l) << 12), v);
        end
      end
    end
    @(posedge core_clk);
    resync_cmd <= 1'b1;
    @(posedge core_clk);
    resync_cmd <= 1'b0;
    #1;
    chk("pending after resync", 24'h000000, 24'(resync_pending));
    d = 24'(rnd() & 32'h00707FFF);
    wr(ecc_pkg::ADDR_CAL, d);
    rd(ecc_pkg::ADDR_CAL, v);
    chk("cal readback", d, v);
    cal_run(0, 1, 2);
    cal_run(3, 1, 1);
    cal_run(1, 1, 1);
    cal_run(0, 1, 0);
    cal_run(0, 0, 5);
    // High time field set too, so a half mode that reads it would show
    wr(ecc_pkg::ADDR_CAL, 24'h400805);
    lv = 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      #1;
      if (n > 0) chk("half duty wave", 24'({lv, lv}),
        24'({cal_source_pos, cal_source_neg}));
      if (n % 5 == 4) lv = ~lv;
      cal_freq_level <= lv;
    end
    print_verdict();
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end
endmodule

bind ecc_config ecc_config_properties chk_i (.core_clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .resync_cmd, .cal_source_pos, .cal_source_neg, .channel_invert,
  .pos_input_isolate, .neg_input_isolate, .pos_to_midsupply_ref, .pos_to_cal_source_pos,
  .pos_to_cal_source_neg, .sample_rate_dsps, .sample_rate_valid, .gain_sel_vv, .cfg_changed,
  .resync_pending);
`default_nettype wire
